//--- src/bcs_regs.svh
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// register port offsets and layout
`define BCS_ADDR_W        4
`define BCS_DATA_W        8
`define BCS_OFS_CTRL      4'h0
`define BCS_OFS_STAT      4'h4
`define BCS_CTRL_HOME_BIT 0
`define BCS_CTRL_RST      1'h0

// synchronised input indices
`define BCS_NIN           11
`define BCS_IN_BTN_N      0
`define BCS_IN_STITCH_N   1
`define BCS_IN_SETUP_N    2
`define BCS_IN_HOME_POS   3
`define BCS_IN_FIRST_POS  4
`define BCS_IN_LOOP_POS   5
`define BCS_IN_SECOND_POS 6
`define BCS_IN_BDONE_N    7
`define BCS_IN_SBDONE_N   8
`define BCS_IN_SPK_DLY    9
`define BCS_IN_SPK_FIRE   10
// idle levels: low-true pins high, flags and spark low, so no false edge
`define BCS_SYNC_RST      11'h187

`endif

//--- src/bcs_pkg.sv
package bcs_pkg;
  // sequencer state and outputs, one flop each except the eight-bit read data
  typedef struct packed {
    logic       home;
    logic       first;
    logic       loop;
    logic       second;
    logic       ot;
    logic       trk_n;
    logic       oneshot;
    logic       bond1;
    logic       bond2;
    logic       spark_ok;
    logic       ctrl_home;
    logic       lamp_home;
    logic       start_n;
    logic [7:0] rdata;
  } bcs_state_t;
endpackage

//--- src/bcs_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bcs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport sync (input raw, output lvl, output rise, output fall);
  modport user (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

//--- src/bcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // raw pins in, clean levels and strobes out
  bcs_sync_if.sync  sif
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } bcs_sync_t;

  bcs_sync_t q;
  bcs_sync_t d;

  // two flops, then a third stage for single-cycle edge strobes
  always_comb begin
    d      = q;
    d.meta = sif.raw;
    d.lvl  = q.meta;
    d.prev = q.lvl;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q <= '{meta: RST, lvl: RST, prev: RST};
    end else begin
      q <= d;
    end
  end

  assign sif.lvl  = q.lvl;
  assign sif.rise = q.lvl & ~q.prev;
  assign sif.fall = ~q.lvl & q.prev;
endmodule
`default_nettype wire

//--- src/bcs_sequencer.sv
// Operation
// - power-on reset enters home state and raises the home request
// - reset clears overtravel and searches; loop held clear while bond two low
// - only home set at start; home flag high clears other states (here only while the home state is also set)
// - first search cannot be set until home flag rises
// - button path to loop exit blocked until spark delivered
// - button press with home flag high sets first search, clears home
// - first search requests position; release at position clears it
// - first search clearing drives tracking low and sets overtravel
// - bond_done_pulse trailing edge with bond two sets loop state
// - bond_done_pulse sets bond-select one-shot, selecting second bond
// - button at loop position clears loop; its fall sets second search
// - second search clears at position, button released, loop clear
// - second-bond-done low resets one-shot, selecting first bond
// - bond_done_pulse trailing edge with bond one sets home state
// - home lamp lights while home flag high
// - stitch button held keeps one-shot set, second bond selected
// - bond select outputs drive the first and second bond lamps
// - home flag or reset switch gives low start for tail control
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_sequencer
  import bcs_pkg::*;
(
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rstn_i,
  // operator controls
  input  wire logic                    operator_push_button_n_i,
  input  wire logic                    stitch_button_n_i,
  input  wire logic                    setup_reset_n_i,
  // position detector flags
  input  wire logic                    home_position_flag_i,
  input  wire logic                    first_position_flag_i,
  input  wire logic                    loop_position_flag_i,
  input  wire logic                    second_position_flag_i,
  // force delay and spark board
  input  wire logic                    bond_done_pulse_n_i,
  input  wire logic                    second_bond_done_n_i,
  input  wire logic                    spark_delay_i,
  input  wire logic                    spark_fire_i,
  // register port
  input  wire logic [`BCS_ADDR_W-1:0]  addr_i,
  input  wire logic [`BCS_DATA_W-1:0]  wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`BCS_DATA_W-1:0]  rdata_o,
  // motor position requests
  output logic                         home_req_o,
  output logic                         first_search_req_o,
  output logic                         loop_req_o,
  output logic                         second_search_req_o,
  // force, tail control and bond select
  output logic                         tracking_force_n_o,
  output logic                         overtravel_o,
  output logic                         start_n_o,
  output logic                         first_bond_sel_o,
  output logic                         second_bond_sel_o,
  // front panel lamps
  output logic                         home_lamp_o,
  output logic                         first_bond_lamp_o,
  output logic                         second_bond_lamp_o
);
  bcs_sync_if #(.W(`BCS_NIN)) sif ();

  bcs_state_t q;
  bcs_state_t d;

  logic btn_dn;
  logic stitch_dn;
  logic home_flag;
  logic force_home;
  logic bd_lead;
  logic bd_trail;

  // every pin but the register port crosses two flops before use
  assign sif.raw = {spark_fire_i, spark_delay_i, second_bond_done_n_i,
                    bond_done_pulse_n_i, second_position_flag_i,
                    loop_position_flag_i, first_position_flag_i,
                    home_position_flag_i, setup_reset_n_i,
                    stitch_button_n_i, operator_push_button_n_i};

  bcs_sync #(
    .W   (`BCS_NIN),
    .RST (`BCS_SYNC_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .sif        (sif)
  );

  // decoded synchronous conditions
  assign btn_dn     = ~sif.lvl[`BCS_IN_BTN_N];
  assign stitch_dn  = ~sif.lvl[`BCS_IN_STITCH_N];
  assign home_flag  = sif.lvl[`BCS_IN_HOME_POS];
  assign force_home = ~sif.lvl[`BCS_IN_SETUP_N] | q.ctrl_home;
  assign bd_lead    = sif.fall[`BCS_IN_BDONE_N];
  assign bd_trail   = sif.rise[`BCS_IN_BDONE_N];

  // next-state logic; later statements take priority over earlier ones
  always_comb begin
    d           = q;
    d.lamp_home = home_flag;
    d.start_n   = ~(home_flag | force_home);
    d.bond2     = q.oneshot;
    d.bond1     = ~q.oneshot;

    // start at home wipes the cycle states; gated by the home state so a
    // press can leave home while the lagging flag is still high
    if (q.home && home_flag) begin
      d.first  = 1'b0;
      d.loop   = 1'b0;
      d.second = 1'b0;
      d.ot     = 1'b0;
      d.trk_n  = 1'b1;
    end

    // release at first position ends the first search
    if (q.first && sif.lvl[`BCS_IN_FIRST_POS] && !btn_dn) begin
      d.first = 1'b0;
    end

    // first search end, gated by second search low, starts tracking
    if (q.first && !d.first && !q.second && !home_flag) begin
      d.trk_n = 1'b0;
    end
    if (q.trk_n && !d.trk_n) begin
      d.ot = 1'b1;
    end

    // bond-select one-shot: set by bond end, cleared by bond two done
    if (bd_lead) begin
      d.oneshot = 1'b1;
    end
    if (!sif.lvl[`BCS_IN_SBDONE_N]) begin
      d.oneshot = 1'b0;
    end
    if (stitch_dn) begin
      d.oneshot = 1'b1;
    end

    // trailing edge gives a short delay before moving the head
    if (bd_trail && q.bond2) begin
      d.loop = 1'b1;
    end
    if (bd_trail && q.bond1) begin
      d.home     = 1'b1;
      d.spark_ok = 1'b0;
    end
    // spark handshake arms the button path; a spark in the clear cycle wins
    if (sif.lvl[`BCS_IN_SPK_DLY] && sif.lvl[`BCS_IN_SPK_FIRE]) begin
      d.spark_ok = 1'b1;
    end

    // loop exit only once the ball has been formed
    if (q.loop && sif.lvl[`BCS_IN_LOOP_POS] && btn_dn && q.spark_ok) begin
      d.loop = 1'b0;
    end
    // bond one selected: loop may not be held
    if (!q.bond2) begin
      d.loop = 1'b0;
    end
    if (q.loop && !d.loop && !home_flag) begin
      d.second = 1'b1;
    end

    // all three conditions needed to leave second search
    if (q.second && sif.lvl[`BCS_IN_SECOND_POS] && !btn_dn && !q.loop) begin
      d.second = 1'b0;
    end

    // home flag guards first search against a premature press
    if (q.home && home_flag && btn_dn) begin
      d.first = 1'b1;
      d.home  = 1'b0;
    end

    // switch on reset or software home acts as power-on reset
    if (force_home) begin
      d.home     = 1'b1;
      d.first    = 1'b0;
      d.loop     = 1'b0;
      d.second   = 1'b0;
      d.ot       = 1'b0;
      d.trk_n    = 1'b1;
      d.oneshot  = 1'b0;
      d.spark_ok = 1'b0;
    end

    // register port: write control, read one cycle later
    if (wr_i && addr_i == `BCS_OFS_CTRL) begin
      d.ctrl_home = wdata_i[`BCS_CTRL_HOME_BIT];
    end
    d.rdata = '0;
    if (rd_i && addr_i == `BCS_OFS_CTRL) begin
      d.rdata = {7'h00, q.ctrl_home};
    end else if (rd_i && addr_i == `BCS_OFS_STAT) begin
      d.rdata = {q.bond2, q.spark_ok, ~q.trk_n, q.ot,
                 q.second, q.loop, q.first, q.home};
    end
  end

  // power-on reset: home and bond one set, tracking force off, everything else cleared
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q <= '{home: 1'b1, first: 1'b0, loop: 1'b0, second: 1'b0,
             ot: 1'b0, trk_n: 1'b1, oneshot: 1'b0, bond1: 1'b1,
             bond2: 1'b0, spark_ok: 1'b0, ctrl_home: `BCS_CTRL_RST,
             lamp_home: 1'b0, start_n: 1'b0, rdata: 8'h00};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign rdata_o             = q.rdata;
  assign home_req_o          = q.home;
  assign first_search_req_o  = q.first;
  assign loop_req_o          = q.loop;
  assign second_search_req_o = q.second;
  assign tracking_force_n_o  = q.trk_n;
  assign overtravel_o        = q.ot;
  assign start_n_o           = q.start_n;
  assign first_bond_sel_o    = q.bond1;
  assign second_bond_sel_o   = q.bond2;
  assign home_lamp_o         = q.lamp_home;
  assign first_bond_lamp_o   = q.bond1;
  assign second_bond_lamp_o  = q.bond2;

  // checks beside the sequence logic
  property p_home_at_reset;
    @(posedge core_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> home_req_o && !first_search_req_o;
  endproperty
  a_home_at_reset: assert property (p_home_at_reset)
    else $error("home not requested after reset");

  property p_loop_held;
    @(posedge core_clk_i) disable iff (!rstn_i)
    !second_bond_sel_o |=> !loop_req_o;
  endproperty
  a_loop_held: assert property (p_loop_held)
    else $error("loop set with bond one selected");

  property p_no_early_first;
    @(posedge core_clk_i) disable iff (!rstn_i)
    !home_flag && !first_search_req_o |=> !first_search_req_o;
  endproperty
  a_no_early_first: assert property (p_no_early_first)
    else $error("first search set before home flag");

  property p_first_set;
    @(posedge core_clk_i) disable iff (!rstn_i)
    home_req_o && home_flag && btn_dn && !force_home
      |=> first_search_req_o && !home_req_o;
  endproperty
  a_first_set: assert property (p_first_set)
    else $error("press at home did not start first search");

  property p_ot_with_track;
    @(posedge core_clk_i) disable iff (!rstn_i)
    $fell(tracking_force_n_o) |-> overtravel_o;
  endproperty
  a_ot_with_track: assert property (p_ot_with_track)
    else $error("tracking without overtravel");

  property p_loop_exit;
    @(posedge core_clk_i) disable iff (!rstn_i)
    loop_req_o && sif.lvl[`BCS_IN_LOOP_POS] && btn_dn && q.spark_ok
      && !home_flag && !force_home |=> !loop_req_o && second_search_req_o;
  endproperty
  a_loop_exit: assert property (p_loop_exit)
    else $error("loop exit did not start second search");

  property p_second_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
    second_search_req_o && !sif.lvl[`BCS_IN_SECOND_POS]
      && !home_flag && !force_home |=> second_search_req_o;
  endproperty
  a_second_hold: assert property (p_second_hold)
    else $error("second search left before position");

  property p_home_lamp;
    @(posedge core_clk_i) disable iff (!rstn_i)
    home_position_flag_i |-> ##3 home_lamp_o;
  endproperty
  a_home_lamp: assert property (p_home_lamp)
    else $error("home lamp dark with home flag high");

  property p_stitch;
    @(posedge core_clk_i) disable iff (!rstn_i)
    stitch_dn && !force_home |=> ##1 second_bond_sel_o && !first_bond_sel_o;
  endproperty
  a_stitch: assert property (p_stitch)
    else $error("stitch did not hold second bond");

  property p_start;
    @(posedge core_clk_i) disable iff (!rstn_i)
    home_flag |=> !start_n_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start not low at home");
endmodule
`default_nettype wire

//--- dv/bcs_pos_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_pos_model #(
  parameter int DLY = 4
) (
  // clock and stall control
  input  wire logic       core_clk_i,
  input  wire logic       hold_i,
  // requests in {home, first, loop, second}, flags out in the same order
  input  wire logic [3:0] req_i,
  output logic      [3:0] flag_o
);
  logic [3:0] pipe_q [DLY];

  // travel time: a flag rises DLY cycles after its request and drops
  // DLY cycles after the request goes, as a head leaving a position
  always_ff @(posedge core_clk_i) begin
    pipe_q[0] <= hold_i ? 4'h0 : req_i;
    for (int i = 1; i < DLY; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end

  // hold models a stalled head that never arrives anywhere
  assign flag_o = hold_i ? 4'h0 : pipe_q[DLY-1];
endmodule
`default_nettype wire

//--- dv/bond_cycle_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bond_cycle_sequencer_tb_top;
  // stimulus, all driven right after a rising edge
  logic       core_clk_i = 1'b0;
  logic       rstn_i     = 1'b0;
  logic       btn_n = 1'b1, st_n = 1'b1, su_n = 1'b1, bd_n = 1'b1;
  logic       sb_n  = 1'b1, sd = 1'b0, sf = 1'b0, hold = 1'b0;
  logic       wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd   = 8'h00;
  // ov = {home, first, loop, second, trk_n, ot, bond1, bond2}
  wire logic [7:0] ov;
  wire logic [7:0] rdat;
  wire logic [3:0] fl;
  wire logic [2:0] lv;
  wire logic       stn;
  int n_fail = 0;
  int n_compared = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  bcs_sequencer bcs_sequencer_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .operator_push_button_n_i(btn_n), .stitch_button_n_i(st_n),
    .setup_reset_n_i(su_n), .home_position_flag_i(fl[3]),
    .first_position_flag_i(fl[2]), .loop_position_flag_i(fl[1]),
    .second_position_flag_i(fl[0]), .bond_done_pulse_n_i(bd_n),
    .second_bond_done_n_i(sb_n), .spark_delay_i(sd), .spark_fire_i(sf),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .home_req_o(ov[7]), .first_search_req_o(ov[6]), .loop_req_o(ov[5]),
    .second_search_req_o(ov[4]), .tracking_force_n_o(ov[3]),
    .overtravel_o(ov[2]), .start_n_o(stn), .first_bond_sel_o(ov[1]),
    .second_bond_sel_o(ov[0]), .home_lamp_o(lv[2]),
    .first_bond_lamp_o(lv[1]), .second_bond_lamp_o(lv[0])
  );

  bcs_pos_model bcs_pos_model_i (
    .core_clk_i(core_clk_i), .hold_i(hold), .req_i(ov[7:4]), .flag_o(fl)
  );

  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // sync depth plus model travel, then step off the edge
  task automatic settle;
    repeat (12) @(posedge core_clk_i);
    #1;
  endtask

  // lamps follow the home flag and the bond selects
  task automatic st(input logic [7:0] e);
    settle;
    cmp(e, ov);
    cmp({5'h0, fl[3], e[1:0]}, {5'h0, lv});
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, e);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    cmp(e, rdat & m);
  endtask

  task automatic bdone;
    @(posedge core_clk_i) bd_n <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    bd_n <= 1'b1;
  endtask

  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    end_of_test;
  end

  // one full bond cycle, then the overrides; status bit 5 reads high
  // while tracking force is requested
  initial begin
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    st(8'h8A);
    cmp(8'h00, {7'h0, stn});
    rd_reg(4'h4, 8'hFF, 8'h01);
    rd_reg(4'h8, 8'hFF, 8'h00);
    wr_reg(4'hC, 8'hFF);
    st(8'h8A);
    @(posedge core_clk_i) hold <= 1'b1;
    btn_n <= 1'b0;
    st(8'h8A);
    @(posedge core_clk_i) hold <= 1'b0;
    btn_n <= 1'b1;
    st(8'h8A);
    @(posedge core_clk_i) btn_n <= 1'b0;
    st(8'h4A);
    cmp(8'h01, {7'h0, stn});
    @(posedge core_clk_i) btn_n <= 1'b1;
    st(8'h06);
    bdone;
    st(8'h25);
    @(posedge core_clk_i) btn_n <= 1'b0;
    st(8'h25);
    @(posedge core_clk_i) btn_n <= 1'b1;
    sd <= 1'b1;
    sf <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    sd <= 1'b0;
    sf <= 1'b0;
    rd_reg(4'h4, 8'hFF, 8'hF4);
    @(posedge core_clk_i) btn_n <= 1'b0;
    st(8'h15);
    @(posedge core_clk_i) btn_n <= 1'b1;
    st(8'h05);
    @(posedge core_clk_i) sb_n <= 1'b0;
    st(8'h06);
    bdone;
    st(8'h8A);
    @(posedge core_clk_i) st_n <= 1'b0;
    sb_n <= 1'b1;
    st(8'h89);
    @(posedge core_clk_i) sb_n <= 1'b0;
    st(8'h89);
    @(posedge core_clk_i) st_n <= 1'b1;
    st(8'h8A);
    @(posedge core_clk_i) sb_n <= 1'b1;
    btn_n <= 1'b0;
    st(8'h4A);
    @(posedge core_clk_i) su_n <= 1'b0;
    st(8'h8A);
    cmp(8'h00, {7'h0, stn});
    @(posedge core_clk_i) btn_n <= 1'b1;
    settle;
    @(posedge core_clk_i) su_n <= 1'b1;
    @(posedge core_clk_i) btn_n <= 1'b0;
    st(8'h4A);
    wr_reg(4'h0, 8'h01);
    st(8'h8A);
    @(posedge core_clk_i) btn_n <= 1'b1;
    settle;
    wr_reg(4'h0, 8'h00);
    st(8'h8A);
    @(posedge core_clk_i) btn_n <= 1'b0;
    st(8'h4A);
    @(posedge core_clk_i) rstn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    cmp(8'h8A, ov);
    @(posedge core_clk_i) btn_n <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    st(8'h8A);
    end_of_test;
  end
endmodule
`default_nettype wire
